// ---- verilog/fsp_ctrl.sv ----
/*
 * flash self-program controller: gates store requests by section and
 * lock, drives the flash macro, stalls the core and keeps the busy flag.
 * assumes a flash macro that pulses flash_done once per started command
 * and a core that honours stall and never sends a store while stalled.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl #(
    parameter int                        PAGE_W     = 5,
    parameter logic [fsp_pkg::ADDR_W-1:0] HALT_START = 12'hC00
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    // fuse pins
    input  wire logic [1:0]                  boot_size_fuses,
    // store requests from the core
    input  wire logic                        store_valid,
    input  wire fsp_pkg::fsp_store_req_t     store_req,
    output logic                             store_refused_q,
    output logic                             stall_q,
    // program memory reads from the core
    input  wire logic                        rd_req,
    input  wire logic [fsp_pkg::ADDR_W-1:0]  rd_pc,
    input  wire logic [fsp_pkg::ADDR_W-1:0]  rd_addr,
    output logic                             rd_ack_q,
    output logic                             rd_deny_q,
    output logic                             crs_block_q,
    // flash macro
    output logic                             flash_go_q,
    output fsp_pkg::fsp_flash_cmd_t          flash_cmd_q,
    input  wire logic                        flash_done,
    // external programming
    input  wire logic                        ext_lock_set,
    input  wire logic [3:0]                  ext_lock_val,
    input  wire logic                        chip_erase,
    // register port
    input  wire logic [fsp_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [fsp_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_we,
    input  wire logic                        reg_re,
    output logic [fsp_pkg::DATA_W-1:0]       reg_rdata_q
);
    localparam int AW = fsp_pkg::ADDR_W;

    typedef enum logic {ST_IDLE, ST_PROG} fsp_state_t;

    fsp_state_t    state_q;
    logic [1:0]    fuse_meta_q;
    logic [1:0]    fuse_q;
    logic [1:0]    app_lock_q;
    logic [1:0]    boot_lock_q;
    logic          crs_busy_q;
    logic          refused_flag_q;
    logic [AW-1:0] boot_size;
    logic [AW-1:0] boot_start;
    logic          pc_in_boot;
    logic          tgt_in_boot;
    logic          tgt_in_halt;
    logic          wr_allowed;
    logic          accept;
    logic          refuse;
    logic          rd_from_boot;
    logic          rd_tgt_boot;
    logic          rd_blocked;
    logic          busy_clr_wr;
    logic          lock_wr;

    ////////////////////////////////////////////////////////////////////////
    // fuse synchroniser
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fuse_meta_q <= fsp_pkg::FUSE_RST;
            fuse_q      <= fsp_pkg::FUSE_RST;
        end
        else
        begin
            fuse_meta_q <= boot_size_fuses;
            fuse_q      <= fuse_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // section decode
    // [RULE3] fuse sized boundary
    assign boot_size  = fsp_pkg::BOOT_MIN_WORDS << (2'h3 - fuse_q);
    assign boot_start = AW'(0) - boot_size;   // boot sits at the top
    assign pc_in_boot  = store_req.pc >= boot_start;
    assign tgt_in_boot = store_req.addr >= boot_start;
    // [RULE6] fixed halting boundary
    // [RULE7] decided by target page
    assign tgt_in_halt = store_req.addr >= HALT_START;

    // store request gating
    // [RULE4] lock pair per section
    // [RULE16] write-blocking lock values
    assign wr_allowed = tgt_in_boot ? boot_lock_q[fsp_pkg::LOCK_WR_BIT]
                                    : app_lock_q[fsp_pkg::LOCK_WR_BIT];
    // [RULE1] application code refused
    // [RULE2] any target from boot
    assign accept = store_valid && (state_q == ST_IDLE) && pc_in_boot
                    && wr_allowed;
    assign refuse = store_valid && !accept;

    assign busy_clr_wr = reg_we && (reg_addr == fsp_pkg::REG_CTRL)
                         && reg_wdata[fsp_pkg::CTRL_BUSY_BIT];
    assign lock_wr     = reg_we && (reg_addr == fsp_pkg::REG_LOCK);

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (accept)
                        state_q <= ST_PROG;
                ST_PROG:
                    if (flash_done)
                        state_q <= ST_IDLE;
            endcase
        end
    end

    // flash command, page aligned
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_go_q  <= 1'b0;
            flash_cmd_q <= '0;
        end
        else
        begin
            flash_go_q <= accept;
            if (accept)
            begin
                // [RULE14] whole page only
                flash_cmd_q.page  <= {store_req.addr[AW-1:PAGE_W],
                                      PAGE_W'(0)};
                flash_cmd_q.erase <= store_req.erase;
            end
        end
    end

    // core stall and concurrent-section read block
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stall_q     <= 1'b0;
            crs_block_q <= 1'b0;
        end
        else if (accept)
        begin
            // [RULE9] halting target stalls
            // [RULE8] concurrent target keeps core running
            stall_q     <= tgt_in_halt;
            crs_block_q <= !tgt_in_halt;
        end
        else if (flash_done)
        begin
            // [RULE18] release on completion
            stall_q     <= 1'b0;
            crs_block_q <= 1'b0;
        end
    end

    // concurrent-section busy flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            crs_busy_q <= 1'b0;
        else if (accept && !tgt_in_halt)
            // [RULE17] set on start
            crs_busy_q <= 1'b1;
        // [RULE12] clear refused while blocked
        // [RULE13] software clear only
        else if (busy_clr_wr && !crs_block_q)
            crs_busy_q <= 1'b0;
    end

    // refusal pulse and sticky refusal flag
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_refused_q <= 1'b0;
            refused_flag_q  <= 1'b0;
        end
        else
        begin
            store_refused_q <= refuse;
            if (refuse)
                refused_flag_q <= 1'b1;   // set wins over clear
            else if (reg_we && (reg_addr == fsp_pkg::REG_CTRL)
                     && reg_wdata[fsp_pkg::CTRL_REFUSE_BIT])
                refused_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock bits: only ever programmed (cleared) except by chip erase
    // [RULE15] set-only, chip erase restores
    // [RULE5] independent pairs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            app_lock_q  <= fsp_pkg::LOCK_RST;
            boot_lock_q <= fsp_pkg::LOCK_RST;
        end
        else if (chip_erase)
        begin
            app_lock_q  <= fsp_pkg::LOCK_RST;
            boot_lock_q <= fsp_pkg::LOCK_RST;
        end
        else
        begin
            app_lock_q <= app_lock_q
                & (lock_wr ? reg_wdata[fsp_pkg::LOCK_APP_LSB +: 2] : 2'h3)
                & (ext_lock_set ? ext_lock_val[fsp_pkg::LOCK_APP_LSB +: 2]
                                : 2'h3);
            boot_lock_q <= boot_lock_q
                & (lock_wr ? reg_wdata[fsp_pkg::LOCK_BOOT_LSB +: 2] : 2'h3)
                & (ext_lock_set ? ext_lock_val[fsp_pkg::LOCK_BOOT_LSB +: 2]
                                : 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program memory read check
    assign rd_from_boot = rd_pc >= boot_start;
    assign rd_tgt_boot  = rd_addr >= boot_start;
    // [RULE16] read-blocking lock values
    assign rd_blocked =
        (rd_from_boot && !rd_tgt_boot && !app_lock_q[fsp_pkg::LOCK_RD_BIT])
        || (!rd_from_boot && rd_tgt_boot
            && !boot_lock_q[fsp_pkg::LOCK_RD_BIT]);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ack_q  <= 1'b0;
            rd_deny_q <= 1'b0;
        end
        else
        begin
            rd_ack_q  <= rd_req;
            rd_deny_q <= rd_req && rd_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, data only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_q <= '0;
        else if (reg_re && reg_addr == fsp_pkg::REG_CTRL)
        begin
            reg_rdata_q <= '0;
            reg_rdata_q[fsp_pkg::CTRL_BUSY_BIT]   <= crs_busy_q;
            reg_rdata_q[fsp_pkg::CTRL_ACTIVE_BIT] <= state_q == ST_PROG;
            reg_rdata_q[fsp_pkg::CTRL_REFUSE_BIT] <= refused_flag_q;
        end
        else if (reg_re && reg_addr == fsp_pkg::REG_LOCK)
            reg_rdata_q <= {4'h0, boot_lock_q, app_lock_q};
        else
            reg_rdata_q <= '0;   // unmapped or idle reads zero
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking fsp_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_app_store_refused: // [RULE1]
        assert property (store_valid && !pc_in_boot
                         |=> store_refused_q && !flash_go_q)
        else $error("store from application code was started");

    a_boot_store_taken: // [RULE2]
        assert property (store_valid && state_q == ST_IDLE && pc_in_boot
                         && wr_allowed |=> flash_go_q ##1 !flash_go_q)
        else $error("permitted boot store not started as one pulse");

    a_boot_in_halt: // [RULE10]
        assert property (boot_start >= HALT_START)
        else $error("boot section reaches below halting boundary");

    a_page_aligned: // [RULE14]
        assert property (flash_go_q |-> flash_cmd_q.page[PAGE_W-1:0] == '0)
        else $error("flash command not page aligned");

    a_halt_stalls: // [RULE9]
        assert property (flash_go_q && flash_cmd_q.page >= HALT_START
                         |-> stall_q throughout (!flash_done [*1]))
        else $error("halting page programmed without stall");

    a_stall_hold: // [RULE9]
        assert property (stall_q && !flash_done |=> stall_q)
        else $error("stall dropped before the operation completed");

    a_conc_runs: // [RULE8]
        assert property (flash_go_q && flash_cmd_q.page < HALT_START
                         |-> !stall_q && crs_block_q && crs_busy_q)
        else $error("concurrent page start wrong stall or busy");

    a_busy_while_block: // [RULE12]
        assert property (crs_block_q |-> crs_busy_q)
        else $error("busy flag low while reads are blocked");

    a_busy_sticky: // [RULE13]
        assert property (crs_busy_q && !busy_clr_wr |=> crs_busy_q)
        else $error("busy flag dropped without software clear");

    a_stall_release: // [RULE18]
        assert property (stall_q && flash_done |=> !stall_q && !crs_block_q)
        else $error("stall not released at completion");

    a_lock_set_only: // [RULE15]
        assert property (!chip_erase |=> ((app_lock_q & ~$past(app_lock_q))
                         | (boot_lock_q & ~$past(boot_lock_q))) == 2'h0)
        else $error("lock bit cleared without chip erase");

    a_app_wr_lock: // [RULE16]
        assert property (store_valid && !tgt_in_boot
                         && !app_lock_q[fsp_pkg::LOCK_WR_BIT]
                         |=> store_refused_q)
        else $error("locked application page accepted a store");

    a_app_rd_lock: // [RULE16]
        assert property (rd_req && rd_from_boot && !rd_tgt_boot
                         && !app_lock_q[fsp_pkg::LOCK_RD_BIT] |=> rd_deny_q)
        else $error("locked application read not denied");

    c_conc_prog: cover property (flash_go_q && !stall_q ##[1:50] flash_done);
    c_halt_prog: cover property (flash_go_q && stall_q ##[1:50] !stall_q);
    c_refused:   cover property (store_valid && !pc_in_boot
                                 ##1 store_refused_q);
    c_busy_clr:  cover property (crs_busy_q && busy_clr_wr ##1 !crs_busy_q);
endmodule : fsp_ctrl
`default_nettype wire

// ---- verilog/fsp_pkg.sv ----
/*
 * constants and carrier types for the flash self-program controller.
 * assumes one core clock domain and a core that presents one store
 * request per cycle at most.
 */
// Behaviour
// [RULE1] store request issued from application code is ignored
// [RULE2] boot-resident store may target any flash page, locks permitting
// [RULE3] boot size fuses set the application/boot boundary
// [RULE4] application lock guards application pages, boot lock guards boot
// [RULE5] the two lock pairs are set independently of each other
// [RULE6] a fixed boundary splits concurrent-read and halting sections
// [RULE7] section choice follows the programmed page, not the fetch address
// [RULE8] concurrent-section operation leaves halting-section reads served
// [RULE9] halting-section operation stalls the core throughout
// [RULE10] boot section always lies inside the halting section
// [RULE11] software avoids concurrent-section reads while it is programmed
// [RULE12] busy flag reads one while concurrent-section reads are blocked
// [RULE13] busy flag stays set until software clears it
// [RULE14] erase and write act on whole pages; reads are unaffected
// [RULE15] lock bits are set by software or programmer, cleared by chip erase
// [RULE16] lock 10 blocks writes, 00 writes and reads, 01 only reads
// [RULE17] concurrent-section operation start sets the busy flag
// [RULE18] stall drops when the halting-section operation completes
////////////////////////////////////////////////////////////////////////////////
package fsp_pkg;
    localparam int                ADDR_W          = 12;
    localparam int                DATA_W          = 8;
    localparam int                REG_AW          = 2;
    // register offsets
    localparam logic [REG_AW-1:0] REG_CTRL        = 2'h0;
    localparam logic [REG_AW-1:0] REG_LOCK        = 2'h1;
    // control register fields
    localparam int                CTRL_BUSY_BIT   = 0;
    localparam int                CTRL_ACTIVE_BIT = 1;
    localparam int                CTRL_REFUSE_BIT = 2;
    // lock register fields
    localparam int                LOCK_APP_LSB    = 0;
    localparam int                LOCK_BOOT_LSB   = 2;
    // lock pair bit 0 low: no writes; bit 1 low: no cross reads
    localparam int                LOCK_WR_BIT     = 0;
    localparam int                LOCK_RD_BIT     = 1;
    localparam logic [1:0]        LOCK_RST        = 2'h3;
    localparam logic [1:0]        FUSE_RST        = 2'h0;
    localparam logic [ADDR_W-1:0] BOOT_MIN_WORDS  = 12'h080;

    typedef struct packed {
        logic [ADDR_W-1:0] pc;      // word address of the issuing code
        logic [ADDR_W-1:0] addr;    // word address of the target
        logic              erase;   // 1 erase, 0 write
    } fsp_store_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] page;    // page-aligned target
        logic              erase;
    } fsp_flash_cmd_t;
endpackage : fsp_pkg

// ---- sim/fsp_flash_model.sv ----
/*
 * flash macro model: one done pulse for every start command.
 * assumes the controller's clock and reset; slow picks a long busy time.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // command side
    input  wire logic go,
    input  wire logic slow,
    output logic      done
);
    logic [4:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // busy count per command, done as it runs out
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 5'h00;
            done  <= 1'b0;
        end
        else
        begin
            done <= (cnt_q == 5'h01);
            if (go)
                cnt_q <= slow ? 5'h14 : 5'h03;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * self-checking bench for the flash self-program controller.
 * assumes default parameters: halting section from 0xC00, 32-word pages.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int           LIMIT = 5000;
    fsp_pkg::fsp_store_req_t store_req;
    fsp_pkg::fsp_flash_cmd_t flash_cmd_q;
    logic        ref_clk, rst_n, store_valid, rd_req, reg_we, reg_re, re_d;
    logic        ext_lock_set, chip_erase, flash_done, fm_slow;
    logic        store_refused_q, stall_q, rd_ack_q, rd_deny_q;
    logic        crs_block_q, flash_go_q;
    logic [1:0]  boot_size_fuses, reg_addr;
    logic [3:0]  ext_lock_val;
    logic [7:0]  reg_wdata, reg_rdata_q;
    logic [11:0] rd_pc, rd_addr, bs;
    logic [31:0] r;
    logic [16:0] expq[$];
    integer      seed, fail_count, comparisons, cycles;

    fsp_ctrl uut (.ref_clk, .rst_n, .boot_size_fuses, .store_valid,
        .store_req, .store_refused_q, .stall_q, .rd_req, .rd_pc, .rd_addr,
        .rd_ack_q, .rd_deny_q, .crs_block_q, .flash_go_q, .flash_cmd_q,
        .flash_done, .ext_lock_set, .ext_lock_val, .chip_erase, .reg_addr,
        .reg_wdata, .reg_we, .reg_re, .reg_rdata_q);
    fsp_flash_model fm (.ref_clk, .rst_n, .go(flash_go_q), .slow(fm_slow),
        .done(flash_done));

    ////////////////////////////////////////////////////////////////////////////
    // clock
    always #5 ref_clk = ~ref_clk;

    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [16:0] e, g);
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
        comparisons++;
    endtask : chk

    task automatic take(input string nm, input logic [16:0] g);
        logic [16:0] e;
        e = 17'h1FFFF;
        if (expq.size() > 0)
            e = expq.pop_front();
        chk(nm, e, g);
    endtask : take

    ////////////////////////////////////////////////////////////////////////////
    // result watcher: oldest note against each result seen
    always @(posedge ref_clk)
        re_d <= reg_re;
    always @(negedge ref_clk)
    begin
        if (flash_go_q || store_refused_q)
            take("store", {2'h1, store_refused_q, flash_go_q,
                 flash_go_q ? flash_cmd_q : 13'h0000});
        if (rd_ack_q)
            take("read check", {2'h2, 14'h0000, rd_deny_q});
        if (re_d)
            take("register", {2'h3, 7'h00, reg_rdata_q});
    end

    // cycle ceiling
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus and request tasks
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        expq.push_back({2'h3, 7'h00, d});
        @(posedge ref_clk);
        reg_re   <= 1'b0;
    endtask : rd

    task automatic store(input logic [11:0] pc, ad, input logic er, no);
        @(posedge ref_clk);
        store_valid <= 1'b1;
        store_req   <= {pc, ad, er};
        expq.push_back({2'h1, no, !no, no ? 13'h0 : {ad[11:5], 5'h00, er}});
        @(posedge ref_clk);
        store_valid <= 1'b0;
    endtask : store

    task automatic look(input logic [11:0] pc, ad, input logic dn);
        @(posedge ref_clk);
        rd_req  <= 1'b1;
        rd_pc   <= pc;
        rd_addr <= ad;
        expq.push_back({2'h2, 14'h0000, dn});
        @(posedge ref_clk);
        rd_req  <= 1'b0;
    endtask : look

    task automatic ext(input logic [3:0] v, input logic er);
        @(posedge ref_clk);
        ext_lock_set <= !er;
        chip_erase   <= er;
        ext_lock_val <= v;
        @(posedge ref_clk);
        ext_lock_set <= 1'b0;
        chip_erase   <= 1'b0;
    endtask : ext

    task automatic finish(input logic st, cb);
        int n;
        n = 0;
        while (flash_done !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("level at done", {st, cb}, {stall_q, crs_block_q});
        @(negedge ref_clk);
        chk("level after done", 17'h0, {stall_q, crs_block_q});
        // hand back on a rising edge so later drives stay edge aligned
        @(posedge ref_clk);
    endtask : finish

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {ref_clk, rst_n, store_valid, rd_req, reg_we, reg_re} = '0;
        {ext_lock_set, chip_erase, fm_slow, re_d} = '0;
        {store_req, rd_pc, rd_addr, reg_addr, reg_wdata, ext_lock_val} = '0;
        boot_size_fuses = 2'h3;
        {fail_count, comparisons, cycles} = '0;
        seed = 32'h3d25;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h0F);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'h00);
        for (int f = 0; f < 4; f++)
        begin
            boot_size_fuses <= f[1:0];
            fm_slow         <= f[0];
            repeat (3) @(posedge ref_clk);
            bs = 12'(16'h1000 - (16'h0080 << (3 - f)));
            r = $random(seed);
            store(bs - 12'h001, 12'hC40, 1'b0, 1'b1);
            store(bs, {bs[11:5], r[4:0]}, f[0], 1'b0);
            finish(1'b1, 1'b0);
        end
        rd(2'h0, 8'h04);
        wr(2'h0, 8'h04);
        rd(2'h0, 8'h00);
        fm_slow <= 1'b1;
        store(12'hF80, {7'h08, r[9:5]}, 1'b1, 1'b0);
        look(12'hF80, 12'hC10, 1'b0);
        rd(2'h0, 8'h03);
        store(12'hF80, 12'hC20, 1'b0, 1'b1);
        wr(2'h0, 8'h01);
        finish(1'b0, 1'b1);
        rd(2'h0, 8'h05);
        wr(2'h0, 8'h05);
        rd(2'h0, 8'h00);
        wr(2'h1, 8'h0E);
        store(12'hF80, 12'h100, 1'b0, 1'b1);
        look(12'hF80, 12'h100, 1'b0);
        wr(2'h1, 8'h0C);
        store(12'hF80, 12'h100, 1'b0, 1'b1);
        look(12'hF80, 12'h100, 1'b1);
        wr(2'h1, 8'h0F);
        rd(2'h1, 8'h0C);
        ext(4'h0, 1'b1);
        rd(2'h1, 8'h0F);
        ext(4'hD, 1'b0);
        store(12'hF80, 12'h100, 1'b0, 1'b0);
        finish(1'b0, 1'b1);
        look(12'hF80, 12'h100, 1'b1);
        ext(4'h3, 1'b0);
        rd(2'h1, 8'h01);
        store(12'hF80, 12'hFA0, 1'b1, 1'b1);
        look(12'h100, 12'hF90, 1'b1);
        wr(2'h0, 8'h05);
        rd(2'h0, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("notes left", 17'h0, 17'(expq.size()));
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
